// ---- core/pd_bcd_digit.sv ----
// module: one bcd down counting decade with synchronous preset load
`timescale 1ns/100ps

module pd_bcd_digit
   import pd_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic step,
   input wire logic load,
   input wire logic [3:0] preset,
   input wire logic [3:0] rst_value,
   output logic [3:0] count,
   output logic at_zero
);

   typedef struct packed {
      logic [3:0] cnt;
   } pd_digit_t;

   pd_digit_t st_ff;
   pd_digit_t nxt_st;

   // ****************************************************************
   // next state
   // ****************************************************************
   always_comb
   begin
      nxt_st = st_ff;
      if (load)
      begin
         nxt_st.cnt = preset;
      end
      else if (step)
      begin
         // wraps from zero to nine, so the top bit rises on the borrow
         nxt_st.cnt = (st_ff.cnt == 4'h0) ? PRESCALE_TOP : st_ff.cnt - 4'h1;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         st_ff.cnt <= rst_value;
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end

   assign count = st_ff.cnt;
   assign at_zero = (st_ff.cnt == 4'h0);

endmodule : pd_bcd_digit

// ---- core/pd_divider.sv ----
// module: programmable divide-by-n synthesizer core with lock detect and register port
//
// Chosen here: the register addresses and the plain strobed port.
`timescale 1ns/100ps

module pd_divider
   import pd_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire logic carrier_only_mode,
   input wire logic keyed_telegraphy_mode,
   input wire logic upper_sideband_mode,
   input wire logic lower_sideband_mode,
   input wire logic reference_output_on,
   input wire logic remote_freq_measure,
   input wire logic osc_in,
   input wire logic ref_500hz_in,
   input wire logic fm_osc_in,
   output logic div_pulse_out,
   output logic lock_out,
   output logic osc_supply_en,
   output logic reference_output_port,
   output logic irq
);

   typedef struct packed {
      logic [PIN_N-1:0] s1;
      logic [PIN_N-1:0] s2;
      logic osc_prev;
      logic ref_prev;
      logic [3:0] pre_units;
      logic [3:0] pre_tens;
      logic div_pulse;
      logic pfd_up;
      logic pfd_dn;
      logic [7:0] err_cnt;
      logic long_seen;
      logic lock;
      logic supply_en;
      logic out_30k;
      logic run;
      logic [IRQ_N-1:0] irq_stat;
      logic [IRQ_N-1:0] irq_mask;
      logic irq;
      logic [31:0] rdata;
      logic [6:0] chk_ticks;
   } pd_state_t;

   pd_state_t st_ff;
   pd_state_t nxt_st;

   logic [PIN_N-1:0] pins;
   logic [3:0] pre_cnt;
   logic pre_zero;
   logic [3:0] units_cnt;
   logic units_zero;
   logic [3:0] tens_cnt;
   logic tens_zero;
   logic osc_rise;
   logic ref_rise;
   logic tick;
   logic reload;
   logic tens_step;
   logic [3:0] dec_units;
   logic [3:0] dec_tens;
   logic mode_any;
   logic [6:0] ratio;

   assign pins = {fm_osc_in, ref_500hz_in, osc_in, remote_freq_measure, reference_output_on,
                  lower_sideband_mode, upper_sideband_mode, keyed_telegraphy_mode,
                  carrier_only_mode};

   // ****************************************************************
   // mode decode and divider control
   // ****************************************************************
   always_comb
   begin
      mode_any = |st_ff.s2[PIN_REF_ON:PIN_CARRIER];
      dec_units = PRE_60_UNITS;
      dec_tens = PRE_60_TENS;
      if (st_ff.s2[PIN_CARRIER] || st_ff.s2[PIN_REF_ON])
      begin
         dec_units = PRE_60_UNITS;
         dec_tens = PRE_60_TENS;
      end
      else if (st_ff.s2[PIN_KEYED])
      begin
         dec_units = PRE_62_UNITS;
         dec_tens = PRE_62_TENS;
      end
      else if (st_ff.s2[PIN_USB])
      begin
         dec_units = PRE_63_UNITS;
         dec_tens = PRE_63_TENS;
      end
      else if (st_ff.s2[PIN_LSB])
      begin
         dec_units = PRE_57_UNITS;
         dec_tens = PRE_57_TENS;
      end
   end

   assign osc_rise = st_ff.s2[PIN_OSC] & ~st_ff.osc_prev;
   assign ref_rise = st_ff.s2[PIN_REF500] & ~st_ff.ref_prev;
   // one tick per ten oscillator edges: the decade prescaler wrapping
   assign tick = osc_rise & pre_zero & st_ff.run;
   // the next step would land on zero in both decades; reloading in its place
   // keeps the all-zero state out of the count so exactly n ticks form a cycle
   assign reload = tick & tens_zero & (units_cnt == 4'h1);
   assign tens_step = tick & units_zero;
   assign ratio = 7'({3'h0, st_ff.pre_tens} * 7'd10) + {3'h0, st_ff.pre_units};

   // ****************************************************************
   // counters
   // ****************************************************************
   pd_bcd_digit u_prescale (
      .sys_clk(sys_clk),
      .rst(rst),
      .step(osc_rise),
      .load(1'b0),
      .preset(PRESCALE_TOP),
      .rst_value(PRESCALE_TOP),
      .count(pre_cnt),
      .at_zero(pre_zero)
   );

   pd_bcd_digit units_down_counter (
      .sys_clk(sys_clk),
      .rst(rst),
      .step(tick),
      .load(reload),
      .preset(dec_units),
      .rst_value(PRE_60_UNITS),
      .count(units_cnt),
      .at_zero(units_zero)
   );

   pd_bcd_digit tens_down_counter (
      .sys_clk(sys_clk),
      .rst(rst),
      .step(tens_step),
      .load(reload),
      .preset(dec_tens),
      .rst_value(PRE_60_TENS),
      .count(tens_cnt),
      .at_zero(tens_zero)
   );

   // ****************************************************************
   // next state
   // ****************************************************************
   always_comb
   begin
      nxt_st = st_ff;
      nxt_st.s1 = pins;
      nxt_st.s2 = st_ff.s1;
      nxt_st.osc_prev = st_ff.s2[PIN_OSC];
      nxt_st.ref_prev = st_ff.s2[PIN_REF500];
      nxt_st.div_pulse = reload;
      nxt_st.chk_ticks = reload ? 7'h0 : (tick ? st_ff.chk_ticks + 7'h1 : st_ff.chk_ticks);
      // preset is only latched at the terminal count, never mid-cycle
      if (reload)
      begin
         nxt_st.pre_units = dec_units;
         nxt_st.pre_tens = dec_tens;
      end
      // phase-frequency detector: edges set, coincidence clears both
      nxt_st.pfd_up = st_ff.pfd_up | ref_rise;
      nxt_st.pfd_dn = st_ff.pfd_dn | st_ff.div_pulse;
      if (nxt_st.pfd_up && nxt_st.pfd_dn)
      begin
         nxt_st.pfd_up = 1'b0;
         nxt_st.pfd_dn = 1'b0;
      end
      // only error pulses longer than the filter count mark loss of lock
      if (st_ff.pfd_up || st_ff.pfd_dn)
      begin
         if (st_ff.err_cnt == FILTER_CNT)
         begin
            nxt_st.long_seen = 1'b1;
         end
         else
         begin
            nxt_st.err_cnt = st_ff.err_cnt + 8'h1;
         end
      end
      else
      begin
         nxt_st.err_cnt = 8'h0;
      end
      if (ref_rise)
      begin
         nxt_st.lock = ~st_ff.long_seen;
         nxt_st.long_seen = 1'b0;
      end
      nxt_st.supply_en = mode_any;
      // remote measure has priority; the two selects are never both high
      if (st_ff.s2[PIN_RFM])
      begin
         nxt_st.out_30k = st_ff.s2[PIN_FMOSC];
      end
      else if (st_ff.s2[PIN_REF_ON])
      begin
         nxt_st.out_30k = (pre_cnt >= 4'h5);
      end
      else
      begin
         nxt_st.out_30k = 1'b0;
      end
      // register writes
      if (reg_wr && reg_addr == OFS_CTRL)
      begin
         nxt_st.run = reg_wdata[CTRL_RUN_BIT];
      end
      if (reg_wr && reg_addr == OFS_IRQ_MASK)
      begin
         nxt_st.irq_mask = reg_wdata[IRQ_N-1:0];
      end
      // clear by writing one; an event in the same cycle wins
      if (reg_wr && reg_addr == OFS_IRQ_STAT)
      begin
         nxt_st.irq_stat = st_ff.irq_stat & ~reg_wdata[IRQ_N-1:0];
      end
      nxt_st.irq_stat[IRQ_LOCK_GAIN] = nxt_st.irq_stat[IRQ_LOCK_GAIN]
                                       | (nxt_st.lock & ~st_ff.lock);
      nxt_st.irq_stat[IRQ_LOCK_LOSS] = nxt_st.irq_stat[IRQ_LOCK_LOSS]
                                       | (~nxt_st.lock & st_ff.lock);
      nxt_st.irq_stat[IRQ_RATIO_CHG] = nxt_st.irq_stat[IRQ_RATIO_CHG]
                                       | (reload && {dec_tens, dec_units}
                                          != {st_ff.pre_tens, st_ff.pre_units});
      nxt_st.irq = |(st_ff.irq_stat & st_ff.irq_mask);
      // register reads: data stand in the next cycle only, unmapped read zero
      nxt_st.rdata = 32'h0000_0000;
      if (reg_rd)
      begin
         unique case (reg_addr)
            OFS_CTRL: nxt_st.rdata[CTRL_RUN_BIT] = st_ff.run;
            OFS_STATUS:
            begin
               nxt_st.rdata[ST_LOCK_BIT] = st_ff.lock;
               nxt_st.rdata[ST_SUPPLY_BIT] = st_ff.supply_en;
               nxt_st.rdata[ST_PRE_UNITS_LSB +: 4] = st_ff.pre_units;
               nxt_st.rdata[ST_PRE_TENS_LSB +: 4] = st_ff.pre_tens;
               nxt_st.rdata[ST_CNT_UNITS_LSB +: 4] = units_cnt;
               nxt_st.rdata[ST_CNT_TENS_LSB +: 4] = tens_cnt;
            end
            OFS_IRQ_STAT: nxt_st.rdata[IRQ_N-1:0] = st_ff.irq_stat;
            OFS_IRQ_MASK: nxt_st.rdata[IRQ_N-1:0] = st_ff.irq_mask;
            default: nxt_st.rdata = 32'h0000_0000;
         endcase
      end
   end

   // ****************************************************************
   // state register
   // ****************************************************************
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         st_ff <= '0;
         st_ff.pre_units <= PRE_60_UNITS;
         st_ff.pre_tens <= PRE_60_TENS;
         st_ff.run <= CTRL_RUN_RST;
         st_ff.irq_mask <= IRQ_MASK_RST;
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end

   assign reg_rdata = st_ff.rdata;
   assign div_pulse_out = st_ff.div_pulse;
   assign lock_out = st_ff.lock;
   assign osc_supply_en = st_ff.supply_en;
   assign reference_output_port = st_ff.out_30k;
   assign irq = st_ff.irq;

   // ****************************************************************
   // assertions
   // ****************************************************************
   sequence seq_units_step;
      tick && !reload && !units_zero;
   endsequence

   sequence seq_units_borrow;
      tick && !reload && units_zero;
   endsequence

   sequence seq_rfm_held;
      st_ff.s2[PIN_RFM] [*2];
   endsequence

   AST_UNITS_DEC: assert property (@(posedge sys_clk) disable iff (rst)
      seq_units_step |=> units_cnt == $past(units_cnt) - 4'h1)
      else $error("units counter did not count down by one");

   AST_TENS_BORROW: assert property (@(posedge sys_clk) disable iff (rst)
      seq_units_borrow |=> units_cnt == PRESCALE_TOP && tens_cnt == $past(tens_cnt) - 4'h1)
      else $error("units wrap did not step tens counter");

   AST_GATE_TENS: assert property (@(posedge sys_clk) disable iff (rst)
      (units_zero && !tens_zero) |=> !div_pulse_out)
      else $error("terminal count while tens counter not zero");

   AST_RELOAD: assert property (@(posedge sys_clk) disable iff (rst)
      reload |=> units_cnt == st_ff.pre_units && tens_cnt == st_ff.pre_tens && st_ff.div_pulse)
      else $error("reload did not preset both counters");

   AST_N_EDGES: assert property (@(posedge sys_clk) disable iff (rst)
      reload && st_ff.chk_ticks != 7'h0 |-> st_ff.chk_ticks + 7'h1 == ratio)
      else $error("reload interval differs from ratio");

   AST_RATIO_SET: assert property (@(posedge sys_clk) disable iff (rst)
      reload |=> ratio == 7'd60 || ratio == 7'd62 || ratio == 7'd63 || ratio == 7'd57)
      else $error("illegal division ratio");

   AST_HOLD_PRESET: assert property (@(posedge sys_clk) disable iff (rst)
      !reload |=> $stable(st_ff.pre_units) && $stable(st_ff.pre_tens))
      else $error("preset changed outside terminal count");

   AST_LOCK_INV: assert property (@(posedge sys_clk) disable iff (rst)
      ref_rise |=> lock_out == !$past(st_ff.long_seen))
      else $error("lock output not inverse of filtered error");

   AST_SUPPLY: assert property (@(posedge sys_clk) disable iff (rst)
      !mode_any [*2] |-> !osc_supply_en)
      else $error("oscillator supply on with no mode");

   AST_RFM_SEL: assert property (@(posedge sys_clk) disable iff (rst)
      seq_rfm_held |=> reference_output_port == $past(st_ff.s2[PIN_FMOSC]))
      else $error("30 kHz output not carrying fm oscillator");

   AST_IRQ: assert property (@(posedge sys_clk) disable iff (rst)
      |(st_ff.irq_stat & st_ff.irq_mask) |=> irq)
      else $error("unmasked status did not raise interrupt");

endmodule : pd_divider

// ---- include/pd_pkg.sv ----
// package: constants, register map and state widths of the pll programmable divider
package pd_pkg;

   // ****************************************************************
   // clock and timing
   // ****************************************************************
   localparam int CLK_PERIOD_PS = 8000;
   // phase error pulses shorter than this are treated as lock glitches
   localparam int PULSE_FILTER_NS = 1000;
   localparam int PULSE_FILTER_CYC = (PULSE_FILTER_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam logic [7:0] FILTER_CNT = 8'(PULSE_FILTER_CYC);

   // ****************************************************************
   // preset codes, units digit then tens digit
   // ****************************************************************
   localparam logic [3:0] PRE_60_UNITS = 4'h0;
   localparam logic [3:0] PRE_60_TENS = 4'h6;
   localparam logic [3:0] PRE_62_UNITS = 4'h2;
   localparam logic [3:0] PRE_62_TENS = 4'h6;
   localparam logic [3:0] PRE_63_UNITS = 4'h3;
   localparam logic [3:0] PRE_63_TENS = 4'h6;
   localparam logic [3:0] PRE_57_UNITS = 4'h7;
   localparam logic [3:0] PRE_57_TENS = 4'h5;
   localparam logic [3:0] PRESCALE_TOP = 4'h9;

   // ****************************************************************
   // synchronised pin positions
   // ****************************************************************
   localparam int PIN_CARRIER = 0;
   localparam int PIN_KEYED = 1;
   localparam int PIN_USB = 2;
   localparam int PIN_LSB = 3;
   localparam int PIN_REF_ON = 4;
   localparam int PIN_RFM = 5;
   localparam int PIN_OSC = 6;
   localparam int PIN_REF500 = 7;
   localparam int PIN_FMOSC = 8;
   localparam int PIN_N = 9;

   // ****************************************************************
   // register map
   // ****************************************************************
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h0C;
   localparam int CTRL_RUN_BIT = 0;
   localparam logic CTRL_RUN_RST = 1'b1;
   localparam int IRQ_LOCK_GAIN = 0;
   localparam int IRQ_LOCK_LOSS = 1;
   localparam int IRQ_RATIO_CHG = 2;
   localparam int IRQ_N = 3;
   localparam logic [2:0] IRQ_MASK_RST = 3'h0;
   // status layout: lock, supply, units preset, tens preset, units count, tens count
   localparam int ST_LOCK_BIT = 0;
   localparam int ST_SUPPLY_BIT = 1;
   localparam int ST_PRE_UNITS_LSB = 4;
   localparam int ST_PRE_TENS_LSB = 8;
   localparam int ST_CNT_UNITS_LSB = 12;
   localparam int ST_CNT_TENS_LSB = 16;

endpackage : pd_pkg

// ---- verif/pd_divider_tb.sv ----
// file: self-checking testbench of the pll programmable divider
`timescale 1ns/100ps

module pd_divider_tb;
   import pd_pkg::*;

   localparam int RATIO_TAB [6] = '{60, 60, 62, 63, 57, 60};
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0000_0000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] reg_rdata;
   logic [2:0] mode_sel = 3'h0;
   logic rfm_req = 1'b0;
   logic [11:0] ref_delay = 12'h014;
   logic [5:0] pins;
   logic osc, ref_500, fm_osc;
   logic div_pulse_out, lock_out, osc_supply_en, reference_output_port, irq;
   logic [2:0] fm_hist = 3'h0;
   logic [31:0] rd;
   int errors = 0;
   int cmp_count = 0;
   int osc_edges = 0;
   int last_edge = 0;
   int ivq[$];
   int cnt;

   pd_divider u_dut (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .carrier_only_mode(pins[0]), .keyed_telegraphy_mode(pins[1]),
      .upper_sideband_mode(pins[2]), .lower_sideband_mode(pins[3]),
      .reference_output_on(pins[4]), .remote_freq_measure(pins[5]), .osc_in(osc),
      .ref_500hz_in(ref_500), .fm_osc_in(fm_osc), .div_pulse_out(div_pulse_out),
      .lock_out(lock_out), .osc_supply_en(osc_supply_en),
      .reference_output_port(reference_output_port), .irq(irq));

   pd_partner u_partner (.sys_clk(sys_clk), .div_pulse(div_pulse_out), .mode_sel(mode_sel),
      .rfm_req(rfm_req), .ref_delay(ref_delay), .pins(pins), .osc(osc),
      .ref_500(ref_500), .fm_osc(fm_osc));

   // ****************************************************************
   // clock and monitors
   // ****************************************************************
   initial forever #4 sys_clk = ~sys_clk;

   always @(posedge osc) osc_edges++;
   always @(posedge sys_clk) fm_hist <= {fm_hist[1:0], fm_osc};

   // reload spacing in oscillator edges; pipeline latency cancels out
   always @(negedge sys_clk)
   begin
      if (div_pulse_out === 1'b1)
      begin
         ivq.push_back(osc_edges - last_edge);
         last_edge = osc_edges;
      end
   end

   // ****************************************************************
   // tasks
   // ****************************************************************
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask : reg_write

   task automatic reg_read(input logic [7:0] a);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      @(negedge sys_clk);
      rd = reg_rdata;
   endtask : reg_read

   task automatic wait_pulses(input int k);
      int t;
      t = 0;
      while (ivq.size() < k && t < 20000)
      begin
         @(negedge sys_clk);
         t++;
      end
      if (ivq.size() < k) chk("pulse count", ivq.size(), k);
   endtask : wait_pulses

   // mode is changed one clock after a reload pulse, so the old ratio must finish first
   task automatic run_mode(input int idx, input int prev);
      ivq.delete();
      wait_pulses(1);
      @(posedge sys_clk);
      mode_sel <= 3'(idx);
      ivq.delete();
      wait_pulses(2);
      chk("old interval", ivq[0], 10 * RATIO_TAB[prev]);
      chk("interval", ivq[1], 10 * RATIO_TAB[idx]);
      chk("supply", osc_supply_en, idx != 0);
      reg_read(OFS_STATUS);
      chk("preset", rd[11:4], {4'(RATIO_TAB[idx] / 10), 4'(RATIO_TAB[idx] % 10)});
   endtask : run_mode

   task print_verdict;
      if (errors == 0 && cmp_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : print_verdict

   // ****************************************************************
   // main sequence
   // ****************************************************************
   initial
   begin
      void'($urandom(32'h1867));
      repeat (6) @(posedge sys_clk);
      rst <= 1'b0;
      reg_read(OFS_CTRL);
      chk("ctrl reset", rd, 32'h0000_0001);
      reg_read(OFS_IRQ_MASK);
      chk("mask reset", rd, 32'h0000_0000);
      reg_read(8'h10);
      chk("unmapped", rd, 32'h0000_0000);
      reg_read(OFS_STATUS);
      chk("reset preset", rd[11:4], 8'h60);
      chk("reset supply", rd[1], 1'b0);
      reg_write(OFS_IRQ_MASK, 32'h0000_0004);
      run_mode(1, 0);
      run_mode(2, 1);
      chk("irq ratio", irq, 1'b1);
      reg_write(OFS_IRQ_MASK, 32'h0000_0000);
      repeat (2) @(posedge sys_clk);
      @(negedge sys_clk);
      chk("irq masked", irq, 1'b0);
      reg_write(OFS_IRQ_STAT, 32'h0000_0004);
      reg_write(OFS_IRQ_MASK, 32'h0000_0004);
      reg_read(OFS_IRQ_STAT);
      chk("w1c", rd[2], 1'b0);
      chk("irq clear", irq, 1'b0);
      run_mode(3, 2);
      run_mode(4, 3);
      run_mode(5, 4);
      cnt = 0;
      repeat (400)
      begin
         @(posedge reference_output_port or negedge sys_clk);
         if (reference_output_port === 1'b1 && sys_clk === 1'b1) cnt++;
      end
      chk("carrier out", cnt >= 9 && cnt <= 11, 1'b1);
      @(posedge sys_clk);
      rfm_req <= 1'b1;
      repeat (5) @(posedge sys_clk);
      repeat (40)
      begin
         @(negedge sys_clk);
         chk("fm out", reference_output_port, fm_hist[2]);
      end
      @(posedge sys_clk);
      rfm_req <= 1'b0;
      run_mode(0, 5);
      chk("port idle", reference_output_port, 1'b0);
      chk("locked", lock_out, 1'b1);
      @(posedge sys_clk);
      ref_delay <= 12'(300 + $urandom % 400);
      ivq.delete();
      wait_pulses(3);
      chk("unlocked", lock_out, 1'b0);
      reg_read(OFS_IRQ_STAT);
      chk("lock events", rd[1:0], 2'b11);
      @(posedge sys_clk);
      ref_delay <= 12'($urandom % 60);
      ivq.delete();
      wait_pulses(3);
      chk("relocked", lock_out, 1'b1);
      reg_write(OFS_CTRL, 32'h0000_0000);
      repeat (4) @(posedge sys_clk);
      ivq.delete();
      repeat (3000) @(negedge sys_clk);
      chk("frozen", ivq.size(), 0);
      reg_write(OFS_CTRL, 32'h0000_0001);
      ivq.delete();
      wait_pulses(2);
      chk("resumed", ivq[1], 600);
      print_verdict();
   end

   initial
   begin
      repeat (100000) @(posedge sys_clk);
      errors++;
      print_verdict();
   end
endmodule : pd_divider_tb

// ---- verif/pd_partner.sv ----
// file: behavioural mode control and oscillator seen across the divider pins
`timescale 1ns/100ps

module pd_partner
(
   input wire logic sys_clk,
   input wire logic div_pulse,
   input wire logic [2:0] mode_sel,
   input wire logic rfm_req,
   input wire logic [11:0] ref_delay,
   output logic [5:0] pins,
   output logic osc,
   output logic ref_500,
   output logic fm_osc
);
   logic [1:0] osc_ph = 2'h0;
   int ph = 100000;
   int fm_cnt = 0;

   // ****************************************************************
   // mode control: one-hot request, remote measure overrides
   // ****************************************************************
   always_comb
   begin
      pins = 6'h00;
      if (mode_sel != 3'h0 && mode_sel <= 3'h5)
      begin
         pins[mode_sel - 3'h1] = 1'b1;
      end
      if (rfm_req)
      begin
         pins[4] = 1'b0;
         pins[5] = 1'b1;
      end
   end

   // ****************************************************************
   // oscillator and reference
   // ****************************************************************
   // the reference is placed a fixed delay after each divided edge, which is
   // what a settled loop shows the comparator; a long delay models lost lock
   initial
   begin
      osc = 1'b0;
      ref_500 = 1'b0;
      fm_osc = 1'b0;
   end

   always @(posedge sys_clk)
   begin
      osc_ph <= osc_ph + 2'h1;
      osc <= osc_ph[1];
      if (div_pulse)
      begin
         ph <= 0;
      end
      else if (ph < 100000)
      begin
         ph <= ph + 1;
      end
      ref_500 <= (ph >= int'(ref_delay)) && (ph < int'(ref_delay) + 1000);
      fm_cnt <= (fm_cnt + 1) % 7;
      if (fm_cnt == 0)
      begin
         fm_osc <= ~fm_osc;
      end
   end
endmodule : pd_partner
